// *** hw/routing_matrix_pkg.sv ***
// Constants shared by the routing matrix, its selector cells and its configuration store.
// Assumes a 4096-bit configuration image laid out as 512 host-addressable bytes.
package routing_matrix_pkg;
	// Matrix dimensions
	localparam int SOURCE_COUNT = 64; // Hard-wired source lines
	localparam int ROUTED_COUNT = 84; // Routed outputs
	localparam int STATE_COUNT = 17; // State-dependent outputs
	localparam int SEL_WIDTH = 6; // Selector field width
	localparam int CONFIG_BITS = 4096; // Whole configuration image
	localparam int ADDR_WIDTH = 9; // Host byte address width
	localparam int BYTE_WIDTH = 8; // Host data width
	// Fixed source line numbers
	localparam int SRC_GROUND = 0; // Constant low
	localparam int SRC_SERIAL_DATA = 32; // Data pin or virtual bit 0
	localparam int SRC_SERIAL_CLOCK = 33; // Clock pin or virtual bit 1
	localparam int SRC_VIRTUAL_HIGH = 34; // Virtual bits 2..7 start here
	localparam int SRC_POWER_ON_RESET = 62; // Core power-on reset, low active
	localparam int SRC_SUPPLY_HIGH = 63; // Constant high
	// Fixed routed output numbers
	localparam int OUT_LOOKUP_IN0 = 0; // Lookup input 0 / flip-flop clock
	localparam int OUT_LOOKUP_IN1 = 1; // Lookup input 1 / flip-flop data
	localparam int OUT_PIN_ZERO_OE = 42; // First bidirectional pin enable
	localparam int OUT_STATE_MACHINE_RESET = 71; // State machine reset, low active
	localparam int OUT_FIRST_OSCILLATOR = 72; // First oscillator enable
	localparam int OUT_SECOND_OSCILLATOR = 73; // Second oscillator enable
	localparam int OUT_THIRD_OSCILLATOR = 74; // Third oscillator enable
	// Configuration image positions
	localparam int VIRTUAL_BIT_LOW = 3800; // Virtual input bit 0
	localparam int PIN_SELECT_BIT = 4084; // 1 selects virtual bits 0 and 1
	localparam int STATE_SEL_BASE = 3808; // First state-dependent selector
	// Host byte addresses
	localparam logic [8:0] VIRTUAL_ADDR = 9'h1DB; // Virtual input register
	localparam logic [8:0] LEVEL_ADDR_FIRST = 9'h1D7; // First output-level byte
	localparam logic [8:0] LEVEL_ADDR_LAST = 9'h1DE; // Last output-level byte
	// Values after reset
	localparam logic [7:0] READ_DATA_RESET = 8'h00; // Host read data
endpackage : routing_matrix_pkg

// *** hw/route_select.sv ***
// One routed output: a 64-to-1 selector steered by a 6-bit field.
// Assumes the field is stable configuration; no clock involved.
`timescale 1ns/10ps
`default_nettype none
module route_select #(
	parameter int SEL_W = 6 // Selector field width
) (
	input wire logic [(1 << SEL_W) - 1:0] sources_in, // All source lines
	input wire logic [SEL_W - 1:0] select_in, // Source number to forward
	output wire logic routed_out // Forwarded level
);
	// Pure combinational pick, no register stage
	assign routed_out = sources_in[select_in];
endmodule : route_select
`default_nettype wire

// *** hw/config_store.sv ***
// Configuration image: loaded whole from one-time memory after each power-on reset.
// Assumes the memory image is stable while reset is released; only the virtual byte is writable.
`timescale 1ns/10ps
`default_nettype none
module config_store (
	input wire logic core_clk_in, // System clock
	input wire logic reset_in, // Power-on reset, high active
	input wire logic [routing_matrix_pkg::CONFIG_BITS - 1:0] nvm_image_in, // Stored image
	input wire logic host_wr_in, // Host write strobe
	input wire logic [routing_matrix_pkg::ADDR_WIDTH - 1:0] host_addr_in, // Host byte address
	input wire logic [routing_matrix_pkg::BYTE_WIDTH - 1:0] host_wdata_in, // Host write data
	output logic [routing_matrix_pkg::CONFIG_BITS - 1:0] config_bits_out, // Live image
	output logic loaded_out // Image valid
);
	logic [routing_matrix_pkg::CONFIG_BITS - 1:0] config_reg; // Live image
	logic [routing_matrix_pkg::CONFIG_BITS - 1:0] config_next; // Next image
	logic loaded_reg; // Load done
	logic loaded_next; // Next load state

	// Load first, then accept only virtual-byte writes
	always_comb begin
		config_next = config_reg;
		loaded_next = 1'b1;
		if (!loaded_reg) begin
			// Reload startup values after reset
			config_next = nvm_image_in;
		end else if (host_wr_in && host_addr_in == routing_matrix_pkg::VIRTUAL_ADDR) begin
			// Host sets the virtual bits
			config_next[routing_matrix_pkg::VIRTUAL_BIT_LOW +: 8] = host_wdata_in;
		end
	end

	// Register image and load flag
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			config_reg <= '0;
			loaded_reg <= 1'b0;
		end else begin
			config_reg <= config_next;
			loaded_reg <= loaded_next;
		end
	end

	assign config_bits_out = config_reg;
	assign loaded_out = loaded_reg;
endmodule : config_store
`default_nettype wire

// *** hw/routing_matrix_virtual_inputs.sv ***
// Routing crossbar with host-writable virtual source lines.
// Assumes synchronous host strobes and pin inputs on the single system clock.
`timescale 1ns/10ps
`default_nettype none
module routing_matrix_virtual_inputs (
	input wire logic core_clk_in, // 125 MHz system clock
	input wire logic reset_in, // Power-on reset, high active
	input wire logic [routing_matrix_pkg::CONFIG_BITS - 1:0] nvm_image_in, // Stored image
	input wire logic [routing_matrix_pkg::SOURCE_COUNT - 1:0] source_lines_in, // Cell outputs
	input wire logic serial_data_pin_input_in, // Serial data pin level
	input wire logic serial_clock_pin_input_in, // Serial clock pin level
	input wire logic [63:0] macrocell_levels_in, // Levels read back by the host; bits 39:32 are hidden behind the virtual byte address
	input wire logic host_wr_in, // Host write strobe
	input wire logic host_rd_in, // Host read strobe
	input wire logic [routing_matrix_pkg::ADDR_WIDTH - 1:0] host_addr_in, // Byte address
	input wire logic [routing_matrix_pkg::BYTE_WIDTH - 1:0] host_wdata_in, // Write data
	output logic [routing_matrix_pkg::BYTE_WIDTH - 1:0] host_rdata_out, // Read data
	output logic host_rvalid_out, // Read data valid pulse
	output wire logic [routing_matrix_pkg::ROUTED_COUNT - 1:0] routed_out, // Routed outputs
	output wire logic [routing_matrix_pkg::STATE_COUNT - 1:0] state_out, // State outputs
	output wire logic two_input_lookup_cell_a_in0_out, // Lookup input 0
	output wire logic two_input_lookup_cell_a_in1_out, // Lookup input 1
	output wire logic pin_zero_output_enable_out, // First pin enable
	output wire logic state_machine_reset_n_out, // State machine reset
	output wire logic [2:0] oscillator_enable_out, // Oscillator enables
	output wire logic core_power_on_reset_n_out // Core reset, low active
);
	localparam int SW = routing_matrix_pkg::SEL_WIDTH; // Field width

	logic [routing_matrix_pkg::CONFIG_BITS - 1:0] config_bits; // Live image
	logic config_loaded; // Image valid
	logic [routing_matrix_pkg::SOURCE_COUNT - 1:0] sources; // Assembled lines
	logic [7:0] virtual_bits; // Host virtual byte
	logic pin_select_virtual; // 1 selects virtual bits
	logic [2:0] level_index; // Level byte number
	logic [routing_matrix_pkg::BYTE_WIDTH - 1:0] rdata_reg; // Read data
	logic [routing_matrix_pkg::BYTE_WIDTH - 1:0] rdata_next; // Next read data
	logic rvalid_reg; // Read valid
	logic rvalid_next; // Next read valid

	// Image storage with reload and virtual writes
	config_store u_store (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.nvm_image_in(nvm_image_in),
		.host_wr_in(host_wr_in),
		.host_addr_in(host_addr_in),
		.host_wdata_in(host_wdata_in),
		.config_bits_out(config_bits),
		.loaded_out(config_loaded)
	);

	// Virtual byte and pin select live in the image
	assign virtual_bits = config_bits[routing_matrix_pkg::VIRTUAL_BIT_LOW +: 8];
	assign pin_select_virtual = config_bits[routing_matrix_pkg::PIN_SELECT_BIT];

	// Source line assembly
	always_comb begin
		sources = source_lines_in;
		sources[routing_matrix_pkg::SRC_GROUND] = 1'b0;
		// Shared lines: pins or virtual bits
		sources[routing_matrix_pkg::SRC_SERIAL_DATA] = pin_select_virtual ?
			virtual_bits[0] : serial_data_pin_input_in;
		sources[routing_matrix_pkg::SRC_SERIAL_CLOCK] = pin_select_virtual ?
			virtual_bits[1] : serial_clock_pin_input_in;
		// Dedicated virtual lines follow the written level
		sources[routing_matrix_pkg::SRC_VIRTUAL_HIGH +: 6] = virtual_bits[7:2];
		// Reset is held low until the image is in
		sources[routing_matrix_pkg::SRC_POWER_ON_RESET] = config_loaded;
		sources[routing_matrix_pkg::SRC_SUPPLY_HIGH] = 1'b1;
	end

	// One selector per routed output
	for (genvar g = 0; g < routing_matrix_pkg::ROUTED_COUNT; g++) begin : g_routed
		route_select #(
			.SEL_W(SW)
		) u_sel (
			.sources_in(sources),
			.select_in(config_bits[g * SW +: SW]),
			.routed_out(routed_out[g])
		);
	end

	// One selector per state-dependent output
	for (genvar s = 0; s < routing_matrix_pkg::STATE_COUNT; s++) begin : g_state
		route_select #(
			.SEL_W(SW)
		) u_sel (
			.sources_in(sources),
			.select_in(config_bits[routing_matrix_pkg::STATE_SEL_BASE + s * SW +: SW]),
			.routed_out(state_out[s])
		);
	end

	// Named destinations of fixed routed outputs and of the image-valid flag
	assign two_input_lookup_cell_a_in0_out = routed_out[routing_matrix_pkg::OUT_LOOKUP_IN0];
	assign two_input_lookup_cell_a_in1_out = routed_out[routing_matrix_pkg::OUT_LOOKUP_IN1];
	assign pin_zero_output_enable_out = routed_out[routing_matrix_pkg::OUT_PIN_ZERO_OE];
	assign state_machine_reset_n_out =
		routed_out[routing_matrix_pkg::OUT_STATE_MACHINE_RESET];
	assign oscillator_enable_out = {
		routed_out[routing_matrix_pkg::OUT_THIRD_OSCILLATOR],
		routed_out[routing_matrix_pkg::OUT_SECOND_OSCILLATOR],
		routed_out[routing_matrix_pkg::OUT_FIRST_OSCILLATOR]
	};
	assign core_power_on_reset_n_out = config_loaded;

	// Level byte number within the read-back window
	assign level_index = 3'(host_addr_in - routing_matrix_pkg::LEVEL_ADDR_FIRST);

	// Host read path: virtual byte, level bytes, else image byte
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = host_rd_in;
		if (host_rd_in) begin
			if (host_addr_in == routing_matrix_pkg::VIRTUAL_ADDR) begin
				// Startup or last written value
				rdata_next = virtual_bits;
			end else if (host_addr_in >= routing_matrix_pkg::LEVEL_ADDR_FIRST &&
				host_addr_in <= routing_matrix_pkg::LEVEL_ADDR_LAST) begin
				// Macrocell output levels
				rdata_next = macrocell_levels_in[{level_index, 3'b000} +: 8];
			end else begin
				// Raw image byte
				rdata_next = config_bits[{host_addr_in, 3'b000} +: 8];
			end
		end
	end

	// Register read answer
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_reg <= routing_matrix_pkg::READ_DATA_RESET;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign host_rdata_out = rdata_reg;
	assign host_rvalid_out = rvalid_reg;

	// Checks on the running design
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);

	// Helper: selector of routed output 0 and 1
	logic [SW - 1:0] sel0; // Field of output 0
	logic [SW - 1:0] sel1; // Field of output 1
	assign sel0 = config_bits[0 +: SW];
	assign sel1 = config_bits[SW +: SW];

	// Line 62 tracks the image-valid reset, seen through output 71
	por_line_a: assert property (
		config_bits[71 * SW +: SW] == 6'h3e |-> state_machine_reset_n_out == config_loaded)
		else $error("Line 62 does not follow the core reset");

	// Line 63 is always high
	supply_line_a: assert property (
		config_bits[72 * SW +: SW] == 6'h3f |-> oscillator_enable_out[0])
		else $error("Line 63 is not high");

	// Output 1 forwards the selected line
	route_pick_a: assert property (
		routed_out[1] == sources[sel1])
		else $error("Output 1 forwards the wrong line");

	// Output 71 forwards its source
	asm_reset_a: assert property (
		state_machine_reset_n_out == sources[config_bits[71 * SW +: SW]])
		else $error("State machine reset forwards the wrong line");

	// Output 72 forwards its source
	osc_enable_a: assert property (
		oscillator_enable_out[0] == sources[config_bits[72 * SW +: SW]])
		else $error("First oscillator enable forwards the wrong line");

	// Output 42 forwards its source
	pin_enable_a: assert property (
		pin_zero_output_enable_out == sources[config_bits[42 * SW +: SW]])
		else $error("Pin enable forwards the wrong line");

	// Written virtual byte appears on the lines next cycle
	virt_write_a: assert property (
		config_loaded && host_wr_in && host_addr_in == 9'h1DB |=>
		virtual_bits == $past(host_wdata_in) && sources[39:34] == $past(host_wdata_in[7:2]))
		else $error("Virtual write did not reach the lines");

	// Virtual byte holds without a write to it
	virt_hold_a: assert property (
		config_loaded && !(host_wr_in && host_addr_in == 9'h1DB) |=> $stable(virtual_bits))
		else $error("Virtual byte changed without a write");

	// Read of the virtual byte returns it one cycle later
	virt_read_a: assert property (
		host_rd_in && host_addr_in == 9'h1DB |=>
		host_rvalid_out && host_rdata_out == $past(virtual_bits))
		else $error("Virtual read returned wrong data");

	// Read of a level byte returns the live level
	level_read_a: assert property (
		host_rd_in && host_addr_in == 9'h1D8 |=>
		host_rdata_out == $past(macrocell_levels_in[15:8]))
		else $error("Level read returned wrong data");

	// Writes elsewhere leave the image untouched
	write_ignore_a: assert property (
		config_loaded && host_addr_in != 9'h1DB |=> $stable(config_bits))
		else $error("Image changed on an ignored write");

	// Pin select routes the serial pins when clear
	pin_select_a: assert property (
		!pin_select_virtual |-> sources[32] == serial_data_pin_input_in &&
		sources[33] == serial_clock_pin_input_in)
		else $error("Shared lines do not carry the pins");

	// Virtual select routes bits 0 and 1
	virt_select_a: assert property (
		pin_select_virtual |-> sources[33:32] == virtual_bits[1:0])
		else $error("Shared lines do not carry virtual bits");

	// Image equals stored image right after the load
	image_reload_a: assert property (
		$rose(config_loaded) |-> config_bits == $past(nvm_image_in))
		else $error("Image not reloaded after reset");

	// Ground line stays low, seen through output 74
	ground_line_a: assert property (
		config_bits[74 * SW +: SW] == 6'h00 |-> !oscillator_enable_out[2])
		else $error("Line 0 is not low");

	// Read answer is a single pulse one cycle after each strobe
	read_pulse_a: assert property (
		host_rvalid_out == $past(host_rd_in))
		else $error("Read valid pulse out of step");

	// Lookup input 0 forwards its selected line
	lookup_pick_a: assert property (
		two_input_lookup_cell_a_in0_out == sources[sel0])
		else $error("Lookup input 0 forwards the wrong line");
endmodule : routing_matrix_virtual_inputs
`default_nettype wire

// *** bench/host_model.sv ***
// Host-side partner: issues single-byte register writes and reads.
// Assumes one-cycle strobes taken at the rising edge of the shared clock.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk_in, // Shared clock
	input wire logic [7:0] rdata_in, // Read data from device
	input wire logic rvalid_in, // Read data valid pulse
	output logic wr_out, // Write strobe
	output logic rd_out, // Read strobe
	output logic [8:0] addr_out, // Byte address
	output logic [7:0] wdata_out // Write data
);
	// Idle bus at time zero
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 9'h000;
		wdata_out = 8'h00;
	end
	// One write strobe; released lines go to the inverse value
	task automatic write_byte(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : write_byte
	// One read strobe; data taken while the valid pulse stands
	task automatic read_byte(input logic [8:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		ok = rvalid_in;
		d = rdata_in;
	endtask : read_byte
endmodule : host_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the routing crossbar with host virtual lines.
// Assumes the host partner in host_model.sv and the design package.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0; // System clock
	logic reset = 1'b1; // Power-on reset
	logic [4095:0] img = '0; // Stored image
	logic [63:0] src = '0; // Source levels
	logic [63:0] lv = 64'h0123_4567_89ab_cdef; // Levels read back
	logic sda = 1'b0; // Serial data pin
	logic scl = 1'b0; // Serial clock pin
	logic wr, rd, rvalid, lk0, lk1, oe0, smr, porn; // Single-bit design ports
	logic [8:0] addr; // Host address
	logic [7:0] wdata, rdata; // Host data
	logic [83:0] routed; // Routed outputs
	logic [16:0] state; // State outputs
	logic [2:0] osc; // Oscillator enables
	logic [7:0] vb; // Expected virtual byte
	logic sel; // Expected pin/virtual choice
	int errors = 0; // Mismatch count
	int n_tests = 0; // Comparison count
	int cycles = 0; // Timeout counter
	// Clock at 125 MHz
	always #4 core_clk = ~core_clk;
	// Cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			final_report();
		end
	end
	routing_matrix_virtual_inputs dut (.core_clk_in(core_clk), .reset_in(reset),
		.nvm_image_in(img), .source_lines_in(src), .serial_data_pin_input_in(sda),
		.serial_clock_pin_input_in(scl), .macrocell_levels_in(lv), .host_wr_in(wr),
		.host_rd_in(rd), .host_addr_in(addr), .host_wdata_in(wdata),
		.host_rdata_out(rdata), .host_rvalid_out(rvalid), .routed_out(routed),
		.state_out(state), .two_input_lookup_cell_a_in0_out(lk0),
		.two_input_lookup_cell_a_in1_out(lk1), .pin_zero_output_enable_out(oe0),
		.state_machine_reset_n_out(smr), .oscillator_enable_out(osc),
		.core_power_on_reset_n_out(porn));
	host_model host (.clk_in(core_clk), .rdata_in(rdata), .rvalid_in(rvalid),
		.wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
	// Compare and count
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Level expected on a source line
	function automatic logic exp_src(input int k);
		if (k == 0) return 1'b0;
		if (k == 62 || k == 63) return 1'b1;
		if (k == 32) return sel ? vb[0] : sda;
		if (k == 33) return sel ? vb[1] : scl;
		if (k >= 34 && k <= 39) return vb[k - 32];
		return src[k];
	endfunction : exp_src
	// Output that forwards source k in the sweep
	function automatic int out_of(input int k);
		return (k < 40) ? k + 2 : k + 3;
	endfunction : out_of
	// Load an image and run a power-on reset
	task automatic boot(input logic [7:0] start, input logic s);
		logic [4095:0] m;
		m = '0;
		for (int k = 0; k < 64; k++) m[6 * out_of(k) +: 6] = 6'(k);
		m[0 +: 6] = 6'h20;
		m[6 +: 6] = 6'h21;
		m[252 +: 6] = 6'h22;
		m[426 +: 6] = 6'h3e;
		m[432 +: 6] = 6'h3f;
		m[438 +: 6] = 6'h27;
		m[444 +: 6] = 6'h00;
		m[3808 +: 6] = 6'h23;
		m[3800 +: 8] = start;
		m[4084] = s;
		vb = start;
		sel = s;
		@(posedge core_clk);
		img <= m;
		reset <= 1'b1;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : boot
	// Drive a source pattern and check each source line through its output, plus the named routed outputs and state output 0
	task automatic sweep(input logic [63:0] p);
		logic [63:0] seen, exp;
		@(posedge core_clk);
		src <= p;
		sda <= p[1];
		scl <= ~p[1];
		#1;
		for (int k = 0; k < 64; k++) begin
			seen[k] = routed[out_of(k)];
			exp[k] = exp_src(k);
		end
		check("routing", seen, exp);
		check("lookup", {lk1, lk0}, {exp_src(33), exp_src(32)});
		check("pin enable", oe0, exp_src(34));
		check("machine reset", smr, exp_src(62));
		check("oscillators", osc, {1'b0, exp_src(39), exp_src(63)});
		check("state output", state[0], exp_src(35));
	endtask : sweep
	// Read one byte and compare
	task automatic rd_chk(input logic [8:0] a, input logic [7:0] e, input string name);
		logic [7:0] d;
		logic ok;
		host.read_byte(a, d, ok);
		check("read valid", ok, 1'b1);
		check(name, d, e);
	endtask : rd_chk
	// Print counts and verdict, then stop
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		boot(8'ha5, 1'b0);
		check("core reset line", porn, 1'b1);
		rd_chk(routing_matrix_pkg::VIRTUAL_ADDR, 8'ha5, "startup byte");
		sweep(64'ha5a5_5a5a_c3c3_3c3d);
		sweep(64'h5a5a_a5a5_3c3c_c3c2);
		$display("test startup done");
		host.write_byte(routing_matrix_pkg::VIRTUAL_ADDR, 8'h3c);
		vb = 8'h3c;
		rd_chk(routing_matrix_pkg::VIRTUAL_ADDR, 8'h3c, "written byte");
		sweep(64'hffff_0000_ffff_0000);
		host.write_byte(9'h1d8, 8'hff);
		rd_chk(9'h1d8, lv[15:8], "level byte");
		host.write_byte(9'h010, 8'hff);
		rd_chk(9'h010, img[128 +: 8], "image byte");
		rd_chk(routing_matrix_pkg::VIRTUAL_ADDR, 8'h3c, "virtual kept");
		$display("test host access done");
		boot(8'h5a, 1'b1);
		rd_chk(routing_matrix_pkg::VIRTUAL_ADDR, 8'h5a, "reloaded byte");
		sweep(64'h0000_ffff_0000_fffd);
		host.write_byte(routing_matrix_pkg::VIRTUAL_ADDR, 8'h03);
		vb = 8'h03;
		sweep(64'h0f0f_f0f0_0f0f_f0f0);
		$display("test virtual select done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
